// ==== shared/ccrb_pkg.sv ====
// ccrb_pkg: constants shared by the codec control register bank
`default_nettype none
package ccrb_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int LEVEL_W = 5;
    localparam int ATT_W = 8;
    localparam int NUM_CH = 9;
    localparam logic [6:0] OFS_RESET = 7'h00;
    localparam logic [6:0] OFS_MASTER = 7'h02;
    localparam logic [6:0] OFS_HEADPHONE = 7'h04;
    localparam logic [6:0] OFS_MONO = 7'h06;
    localparam logic [6:0] OFS_AUX = 7'h16;
    localparam logic [6:0] OFS_FRONT = 7'h18;
    localparam logic [6:0] OFS_REC_SEL = 7'h1a;
    localparam logic [6:0] OFS_REC_GAIN = 7'h1c;
    localparam logic [6:0] OFS_GP = 7'h20;
    localparam logic [6:0] OFS_INT_PAGE = 7'h24;
    localparam logic [6:0] OFS_PWR = 7'h26;
    localparam logic [6:0] OFS_EXT_ID = 7'h28;
    localparam logic [6:0] OFS_EXT_CTL = 7'h2a;
    localparam logic [6:0] OFS_RATE_FRONT = 7'h2c;
    localparam logic [6:0] OFS_RATE_SURR = 7'h2e;
    localparam logic [6:0] OFS_RATE_CSUB = 7'h30;
    localparam logic [6:0] OFS_RATE_ADC = 7'h32;
    localparam logic [6:0] OFS_CSUB_VOL = 7'h36;
    localparam logic [6:0] OFS_SURR_VOL = 7'h38;
    localparam logic [6:0] OFS_DOUT_CTL = 7'h3a;
    localparam logic [6:0] OFS_EQ_CTL = 7'h60;
    localparam logic [6:0] OFS_EQUALIZER_COEFFICIENT_DATA = 7'h62;
    localparam logic [6:0] OFS_MISC2 = 7'h70;
    localparam logic [6:0] OFS_JACK1 = 7'h72;
    localparam logic [6:0] OFS_LINK_CFG = 7'h74;
    localparam logic [6:0] OFS_MISC1 = 7'h76;
    localparam logic [6:0] OFS_JACK2 = 7'h78;
    localparam logic [6:0] OFS_MISC3 = 7'h7a;
    localparam logic [6:0] OFS_MAKER_HI = 7'h7c;
    localparam logic [6:0] OFS_MAKER_LO = 7'h7e;
    // page-one window overlays 0x60..0x6a while the page field is PAGE_ONE
    localparam logic [6:0] PG1_CLASS = 7'h60;
    localparam logic [6:0] PG1_SENSE = 7'h6a;
    localparam logic [3:0] PAGE_ONE = 4'h1;
    localparam int PAGE_LSB = 0;
    localparam int PAGE_W = 4;
    localparam logic [2:0] PG1_I_CLASS = 3'h0;
    localparam logic [2:0] PG1_I_SVID = 3'h1;
    localparam logic [2:0] PG1_I_SID = 3'h2;
    localparam logic [2:0] PG1_I_FINFO = 3'h4;
    localparam logic [2:0] PG1_I_SENSE = 3'h5;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_MUTED_PAIR = 16'h8080;
    localparam logic [15:0] RST_MONO = 16'h8000;
    localparam logic [15:0] RST_MIXER_PAIR = 16'h8888;
    localparam logic [15:0] RST_EXT_ID = 16'h0bc7;
    localparam logic [15:0] RST_RATE = 16'hbb80;
    localparam logic [15:0] RST_DOUT = 16'h2000;
    localparam logic [15:0] RST_LINK = 16'h1001;
    localparam logic [15:0] RST_MISC1 = 16'h6010;
    localparam logic [15:0] RST_PG1_CLASS = 16'h0002;
    localparam logic [15:0] RST_PG1_ID = 16'hffff;
    // write masks: a zero bit is read-only and holds its default; link keep bits survive software reset only, sense keep bits both weaker resets
    localparam logic [15:0] MSK_NONE = 16'h0000;
    localparam logic [15:0] MSK_ALL = 16'hffff;
    localparam logic [15:0] MSK_STEREO = 16'h9f9f;
    localparam logic [15:0] MSK_MONO = 16'h801f;
    localparam logic [15:0] MSK_REC_SEL = 16'h0707;
    localparam logic [15:0] MSK_REC_GAIN = 16'h8f0f;
    localparam logic [15:0] MSK_PAGE = 16'h000f;
    localparam logic [15:0] MSK_PWR = 16'hff00;
    localparam logic [15:0] MSK_EXT_CTL = 16'h0037;
    localparam logic [15:0] MSK_MISC1 = 16'h9bff;
    localparam logic [15:0] MSK_LINK_KEEP = 16'hf087;
    localparam logic [15:0] MSK_SENSE_KEEP = 16'he000;
    localparam logic [9:0] CAP_FIELD = 10'h290;
    localparam logic [4:0] SE_NONE = 5'h00;
    localparam int LMUTE_BIT = 15;
    localparam int LLEV_LSB = 8;
    localparam int RMUTE_BIT = 7;
    localparam int RLEV_LSB = 0;
    localparam int PWR_REQ_LSB = 8;
    localparam int PWR_RDY_W = 4;
    localparam int EAPD_BIT = 15;
    localparam int GPO_BIT = 3;
    localparam logic [4:0] DAC_UNITY_CODE = 5'h08;
    localparam logic [4:0] OUT_UNITY_CODE = 5'h00;
    localparam int CH_LINE_L = 0;
    localparam int CH_LINE_R = 1;
    localparam int CH_SURR_L = 2;
    localparam int CH_SURR_R = 3;
    localparam int CH_CENTRE = 4;
    localparam int CH_SUB = 5;
    localparam int CH_HP_L = 6;
    localparam int CH_HP_R = 7;
    localparam int CH_MONO = 8;
endpackage : ccrb_pkg
`default_nettype wire

// ==== rtl/ccrb_gain_stage.sv ====
// ccrb_gain_stage: registered mute and net attenuation of one output channel
`timescale 1ns/100ps
`default_nettype none

module ccrb_gain_stage #(
    parameter logic [ccrb_pkg::LEVEL_W-1:0] ZERO_DB_CODE = 5'h00
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic master_mute_i,
    input wire logic [ccrb_pkg::LEVEL_W-1:0] master_level_i,
    input wire logic local_mute_i,
    input wire logic [ccrb_pkg::LEVEL_W-1:0] local_level_i,
    output logic mute_o,
    output logic [ccrb_pkg::ATT_W-1:0] atten_o
);
    import ccrb_pkg::*;

    typedef struct packed {
        logic mute;
        logic [ATT_W-1:0] atten;
    } ccrb_gain_state_type;

    ccrb_gain_state_type st_ff;
    ccrb_gain_state_type nxt_st;

    // net attenuation in 1.5 dB steps, two's complement; negative means gain
    always_comb begin
        nxt_st.mute = master_mute_i | local_mute_i;
        nxt_st.atten = {{(ATT_W-LEVEL_W){1'b0}}, master_level_i}
                     + {{(ATT_W-LEVEL_W){1'b0}}, local_level_i}
                     - {{(ATT_W-LEVEL_W){1'b0}}, ZERO_DB_CODE};
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '{mute: 1'b1, atten: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mute_o = st_ff.mute;
    assign atten_o = st_ff.atten;
endmodule : ccrb_gain_stage
`default_nettype wire

// ==== rtl/ccrb_top.sv ====
// ccrb_top: codec control register bank with reset tiers and volume routing
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module ccrb_top #(
    parameter logic [15:0] MAKER_CODE_HI = 16'h5a5a, // arbitrary value
    parameter logic [15:0] MAKER_CODE_LO = 16'ha5a5 // arbitrary value
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic hw_reset_n_i,
    input wire logic [ccrb_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ccrb_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ccrb_pkg::DATA_W-1:0] rdata_o,
    output logic [ccrb_pkg::DATA_W-1:0] link_configuration_o,
    output logic [ccrb_pkg::DATA_W-1:0] power_down_ctrl_o,
    output logic eapd_o,
    output logic general_purpose_o,
    output logic [ccrb_pkg::NUM_CH-1:0] chan_mute_o,
    output logic [ccrb_pkg::NUM_CH-1:0][ccrb_pkg::ATT_W-1:0] chan_atten_o
);
    import ccrb_pkg::*;

    // one word per even address; odd addresses fall between words
    localparam int NUM_REGS = 2 ** (ADDR_W - 1);
    localparam int NUM_PG1 = 6;
    localparam int RIDX_W = ADDR_W - 1;

    // page-one words sit apart so the page field can overlay them
    // only hw_sync is read: hw_meta may still be settling from the pin
    typedef struct packed {
        logic hw_meta;
        logic hw_sync;
        logic [NUM_REGS-1:0][DATA_W-1:0] regs;
        logic [NUM_PG1-1:0][DATA_W-1:0] pg1;
        logic [DATA_W-1:0] rdata;
    } ccrb_state_type;

    // default contents of each page-zero word; unlisted words stay zero
    function automatic logic [15:0] def_val(input logic [6:0] ofs);
        case (ofs)
            OFS_RESET:
                def_val = {1'b0, SE_NONE, CAP_FIELD};
            OFS_MASTER,
            OFS_HEADPHONE,
            OFS_REC_GAIN,
            OFS_EQ_CTL:
                def_val = RST_MUTED_PAIR;
            OFS_MONO:
                def_val = RST_MONO;
            OFS_AUX,
            OFS_FRONT,
            OFS_CSUB_VOL,
            OFS_SURR_VOL:
                def_val = RST_MIXER_PAIR;
            OFS_EXT_ID:
                def_val = RST_EXT_ID;
            OFS_RATE_FRONT,
            OFS_RATE_SURR,
            OFS_RATE_CSUB,
            OFS_RATE_ADC:
                def_val = RST_RATE;
            OFS_DOUT_CTL:
                def_val = RST_DOUT;
            OFS_LINK_CFG:
                def_val = RST_LINK;
            OFS_MISC1:
                def_val = RST_MISC1;
            OFS_MAKER_HI:
                def_val = MAKER_CODE_HI;
            OFS_MAKER_LO:
                def_val = MAKER_CODE_LO;
            default:
                def_val = RST_ZERO;
        endcase
    endfunction : def_val

    // writable bits; reserved and read-only bits keep their default for good
    function automatic logic [15:0] wr_mask(input logic [6:0] ofs);
        case (ofs)
            OFS_MASTER,
            OFS_HEADPHONE,
            OFS_AUX,
            OFS_FRONT,
            OFS_CSUB_VOL,
            OFS_SURR_VOL:
                wr_mask = MSK_STEREO;
            OFS_MONO:
                wr_mask = MSK_MONO;
            OFS_REC_SEL:
                wr_mask = MSK_REC_SEL;
            OFS_REC_GAIN:
                wr_mask = MSK_REC_GAIN;
            OFS_INT_PAGE:
                wr_mask = MSK_PAGE;
            OFS_PWR:
                wr_mask = MSK_PWR;
            OFS_EXT_CTL:
                wr_mask = MSK_EXT_CTL;
            OFS_MISC1:
                wr_mask = MSK_MISC1;
            OFS_GP,
            OFS_RATE_FRONT,
            OFS_RATE_SURR,
            OFS_RATE_CSUB,
            OFS_RATE_ADC,
            OFS_DOUT_CTL,
            OFS_EQ_CTL,
            OFS_EQUALIZER_COEFFICIENT_DATA,
            OFS_MISC2,
            OFS_JACK1,
            OFS_LINK_CFG,
            OFS_JACK2,
            OFS_MISC3:
                wr_mask = MSK_ALL;
            default:
                wr_mask = MSK_NONE;
        endcase
    endfunction : wr_mask

    // page-one defaults: class code and all-ones ids, the rest zero
    function automatic logic [15:0] pg1_def(input logic [2:0] idx);
        case (idx)
            PG1_I_CLASS:
                pg1_def = RST_PG1_CLASS;
            PG1_I_SVID,
            PG1_I_SID:
                pg1_def = RST_PG1_ID;
            default:
                pg1_def = RST_ZERO;
        endcase
    endfunction : pg1_def

    // page-one bits that ride through software and pin resets
    function automatic logic [15:0] pg1_keep(input logic [2:0] idx);
        case (idx)
            PG1_I_CLASS,
            PG1_I_SVID,
            PG1_I_SID,
            PG1_I_FINFO:
                pg1_keep = MSK_ALL;
            PG1_I_SENSE:
                pg1_keep = MSK_SENSE_KEEP;
            default:
                pg1_keep = MSK_NONE;
        endcase
    endfunction : pg1_keep

    // a section reports ready while its power-down request is clear
    function automatic logic [15:0] power_word(input logic [15:0] ctrl);
        power_word = ctrl;
        power_word[PWR_RDY_W-1:0] = ~ctrl[PWR_REQ_LSB +: PWR_RDY_W];
    endfunction : power_word

    // power-on image; the weaker resets copy from it, bar the bits they keep
    function automatic ccrb_state_type por_state();
        ccrb_state_type s;
        s = '0;
        s.hw_meta = 1'b1;
        s.hw_sync = 1'b1;
        for (int i = 0; i < NUM_REGS; i++) begin
            s.regs[i] = def_val(7'(i * 2));
        end
        for (int i = 0; i < NUM_PG1; i++) begin
            s.pg1[i] = pg1_def(3'(i));
        end
        por_state = s;
    endfunction : por_state

    localparam ccrb_state_type ST_POR = por_state();

    ccrb_state_type st_ff;
    ccrb_state_type nxt_st;

    always_comb begin
        logic hw_rst;
        logic sw_rst;
        logic pg1_hit;
        logic [2:0] pidx;
        logic [RIDX_W-1:0] ridx;
        logic [DATA_W-1:0] msk;
        logic [DATA_W-1:0] keep;

        hw_rst = !st_ff.hw_sync;
        // whatever data is written, a write to the reset word resets the bank
        sw_rst = wr_i && (addr_i == OFS_RESET);
        ridx = addr_i[ADDR_W-1:1];
        pidx = 3'((addr_i - PG1_CLASS) >> 1);
        // outside page one the window is the equalizer pair and four read-only zero words
        pg1_hit = (st_ff.regs[OFS_INT_PAGE[6:1]][PAGE_LSB +: PAGE_W] == PAGE_ONE)
                  && (addr_i >= PG1_CLASS)
                  && (addr_i <= PG1_SENSE);
        msk = wr_mask(addr_i);
        keep = MSK_NONE;

        nxt_st = st_ff;
        nxt_st.hw_meta = hw_reset_n_i;
        nxt_st.hw_sync = st_ff.hw_meta;
        // read data stand for one cycle only, then fall back to zero
        nxt_st.rdata = '0;

        // odd byte addresses fall between words: they read zero and ignore writes
        if (rd_i && !addr_i[0]) begin
            if (pg1_hit) begin
                nxt_st.rdata = st_ff.pg1[pidx];
            end else if (addr_i == OFS_PWR) begin
                nxt_st.rdata = power_word(st_ff.regs[ridx]);
            end else begin
                nxt_st.rdata = st_ff.regs[ridx];
            end
        end
        if (wr_i && !addr_i[0] && !sw_rst) begin
            if (pg1_hit) begin
                nxt_st.pg1[pidx] = wdata_i;
            end else begin
                nxt_st.regs[ridx] = (st_ff.regs[ridx] & ~msk) | (wdata_i & msk);
            end
        end

        // the pin reset is held for as long as the pin is low, so it wins over writes
        if (sw_rst || hw_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                nxt_st.regs[i] = ST_POR.regs[i];
            end
            // only the pin clears the protected link bits
            if (!hw_rst) begin
                keep = MSK_LINK_KEEP;
            end
            nxt_st.regs[OFS_LINK_CFG[6:1]] = (ST_POR.regs[OFS_LINK_CFG[6:1]] & ~keep)
                | (st_ff.regs[OFS_LINK_CFG[6:1]] & keep);
            // sticky page-one bits ride through both weaker resets
            for (int i = 0; i < NUM_PG1; i++) begin
                nxt_st.pg1[i] = (ST_POR.pg1[i] & ~pg1_keep(3'(i)))
                    | (st_ff.pg1[i] & pg1_keep(3'(i)));
            end
        end
    end

    // reset only ever loads the constant power-on image
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= ST_POR;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // routing taps: plain wiring from the state image into the gain stages
    logic [DATA_W-1:0] mst_word;
    logic [DATA_W-1:0] hp_word;
    logic [DATA_W-1:0] mono_word;
    logic [DATA_W-1:0] front_word;
    logic [DATA_W-1:0] surr_word;
    logic [DATA_W-1:0] csub_word;
    logic [NUM_CH-1:0] m_mute;
    logic [NUM_CH-1:0] l_mute;
    logic [NUM_CH-1:0][LEVEL_W-1:0] m_lvl;
    logic [NUM_CH-1:0][LEVEL_W-1:0] l_lvl;

    assign mst_word = st_ff.regs[OFS_MASTER[6:1]];
    assign hp_word = st_ff.regs[OFS_HEADPHONE[6:1]];
    assign mono_word = st_ff.regs[OFS_MONO[6:1]];
    assign front_word = st_ff.regs[OFS_FRONT[6:1]];
    assign surr_word = st_ff.regs[OFS_SURR_VOL[6:1]];
    assign csub_word = st_ff.regs[OFS_CSUB_VOL[6:1]];

    // master stacks on the per-DAC level for the three speaker pairs
    assign m_mute[CH_LINE_L] = mst_word[LMUTE_BIT];
    assign m_lvl[CH_LINE_L] = mst_word[LLEV_LSB +: LEVEL_W];
    assign l_mute[CH_LINE_L] = front_word[LMUTE_BIT];
    assign l_lvl[CH_LINE_L] = front_word[LLEV_LSB +: LEVEL_W];

    assign m_mute[CH_LINE_R] = mst_word[RMUTE_BIT];
    assign m_lvl[CH_LINE_R] = mst_word[RLEV_LSB +: LEVEL_W];
    assign l_mute[CH_LINE_R] = front_word[RMUTE_BIT];
    assign l_lvl[CH_LINE_R] = front_word[RLEV_LSB +: LEVEL_W];

    // surround follows the same master halves as the line pair
    assign m_mute[CH_SURR_L] = mst_word[LMUTE_BIT];
    assign m_lvl[CH_SURR_L] = mst_word[LLEV_LSB +: LEVEL_W];
    assign l_mute[CH_SURR_L] = surr_word[LMUTE_BIT];
    assign l_lvl[CH_SURR_L] = surr_word[LLEV_LSB +: LEVEL_W];

    assign m_mute[CH_SURR_R] = mst_word[RMUTE_BIT];
    assign m_lvl[CH_SURR_R] = mst_word[RLEV_LSB +: LEVEL_W];
    assign l_mute[CH_SURR_R] = surr_word[RMUTE_BIT];
    assign l_lvl[CH_SURR_R] = surr_word[RLEV_LSB +: LEVEL_W];

    // centre sits in the right half of its register, subwoofer in the left
    assign m_mute[CH_CENTRE] = mst_word[RMUTE_BIT];
    assign m_lvl[CH_CENTRE] = mst_word[RLEV_LSB +: LEVEL_W];
    assign l_mute[CH_CENTRE] = csub_word[RMUTE_BIT];
    assign l_lvl[CH_CENTRE] = csub_word[RLEV_LSB +: LEVEL_W];

    assign m_mute[CH_SUB] = mst_word[LMUTE_BIT];
    assign m_lvl[CH_SUB] = mst_word[LLEV_LSB +: LEVEL_W];
    assign l_mute[CH_SUB] = csub_word[LMUTE_BIT];
    assign l_lvl[CH_SUB] = csub_word[LLEV_LSB +: LEVEL_W];

    // headphone and mono ignore the master register entirely
    assign m_mute[CH_HP_L] = 1'b0;
    assign m_lvl[CH_HP_L] = OUT_UNITY_CODE;
    assign l_mute[CH_HP_L] = hp_word[LMUTE_BIT];
    assign l_lvl[CH_HP_L] = hp_word[LLEV_LSB +: LEVEL_W];

    assign m_mute[CH_HP_R] = 1'b0;
    assign m_lvl[CH_HP_R] = OUT_UNITY_CODE;
    assign l_mute[CH_HP_R] = hp_word[RMUTE_BIT];
    assign l_lvl[CH_HP_R] = hp_word[RLEV_LSB +: LEVEL_W];

    // mono takes its mute from bit 15 and its level from the low field
    assign m_mute[CH_MONO] = 1'b0;
    assign m_lvl[CH_MONO] = OUT_UNITY_CODE;
    assign l_mute[CH_MONO] = mono_word[LMUTE_BIT];
    assign l_lvl[CH_MONO] = mono_word[RLEV_LSB +: LEVEL_W];

    // DAC level registers centre 0 dB on code 8, output registers on code 0
    // no clamping: a sum past 31 steps is passed on for the analog side to limit
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        ccrb_gain_stage #(
            .ZERO_DB_CODE((c < CH_HP_L)
                ? DAC_UNITY_CODE
                : OUT_UNITY_CODE)
        ) u_gain (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .master_mute_i(m_mute[c]),
            .master_level_i(m_lvl[c]),
            .local_mute_i(l_mute[c]),
            .local_level_i(l_lvl[c]),
            .mute_o(chan_mute_o[c]),
            .atten_o(chan_atten_o[c])
        );
    end

    // every output is a flop of the state image or of a gain stage
    assign rdata_o = st_ff.rdata;
    assign link_configuration_o = st_ff.regs[OFS_LINK_CFG[6:1]];
    assign power_down_ctrl_o = st_ff.regs[OFS_PWR[6:1]];
    assign eapd_o = st_ff.regs[OFS_PWR[6:1]][EAPD_BIT];
    assign general_purpose_o = st_ff.regs[OFS_MISC3[6:1]][GPO_BIT];
endmodule : ccrb_top
`default_nettype wire

// ==== dv/ccrb_checker.sv ====
// ccrb_checker: port-level assertions for the codec control register bank
`timescale 1ns/100ps
`default_nettype none
module ccrb_checker (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic hw_reset_n_i,
    input wire logic [ccrb_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ccrb_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ccrb_pkg::DATA_W-1:0] rdata_o,
    input wire logic [ccrb_pkg::DATA_W-1:0] link_configuration_o,
    input wire logic [ccrb_pkg::DATA_W-1:0] power_down_ctrl_o,
    input wire logic eapd_o,
    input wire logic general_purpose_o,
    input wire logic [ccrb_pkg::NUM_CH-1:0] chan_mute_o,
    input wire logic [ccrb_pkg::NUM_CH-1:0][ccrb_pkg::ATT_W-1:0] chan_atten_o
);
    import ccrb_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // pin high for three samples means the synchroniser cannot reset at the write edge
    sequence pin_quiet_s;
        hw_reset_n_i[*3];
    endsequence
    cap_read_a: assert property (rd_i && addr_i == 7'h00 |=> rdata_o == 16'h0290)
        else $error("reset register read wrong");
    ext_id_a: assert property (rd_i && addr_i == 7'h28 |=> rdata_o[15:14] == 2'b00)
        else $error("extended id bits not zero");
    compat_bits_a: assert property (rd_i && addr_i == 7'h76 |=> rdata_o[14:13] == 2'b11)
        else $error("compat bits not one");
    sw_link_keep_a: assert property (pin_quiet_s ##0 (wr_i && addr_i == 7'h00) |=>
        (link_configuration_o & 16'h0f78) == 16'h0000 &&
        (link_configuration_o & 16'hf087) == ($past(link_configuration_o) & 16'hf087))
        else $error("software reset altered protected link bits");
    sw_mute_all_a: assert property (wr_i && addr_i == 7'h00 |-> ##2 chan_mute_o == 9'h1ff)
        else $error("software reset left a channel unmuted");
    hw_link_clear_a: assert property ((!hw_reset_n_i)[*3] |=> link_configuration_o == 16'h1001)
        else $error("pin reset did not clear link config");
    master_mute_a: assert property (pin_quiet_s ##0 (wr_i && addr_i == 7'h02 && wdata_i[15] && wdata_i[7])
        |-> ##2 chan_mute_o[5:0] == 6'h3f)
        else $error("master mute missed an output");
    hp_map_a: assert property (pin_quiet_s ##0 (wr_i && addr_i == 7'h04) |-> ##2
        chan_mute_o[7:6] == {$past(wdata_i[7], 2), $past(wdata_i[15], 2)} &&
        chan_atten_o[6] == {3'h0, $past(wdata_i[12:8], 2)} && chan_atten_o[7] == {3'h0, $past(wdata_i[4:0], 2)})
        else $error("headphone channel mismatch");
    mono_map_a: assert property (pin_quiet_s ##0 (wr_i && addr_i == 7'h06) |-> ##2
        chan_mute_o[8] == $past(wdata_i[15], 2) && chan_atten_o[8] == {3'h0, $past(wdata_i[4:0], 2)})
        else $error("mono channel mismatch");
    sw_reset_c: cover property (pin_quiet_s ##0 (wr_i && addr_i == 7'h00));
    pin_reset_c: cover property ((!hw_reset_n_i)[*3]);
    page_read_c: cover property (rd_i && addr_i == 7'h60);
endmodule : ccrb_checker
bind ccrb_top ccrb_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .hw_reset_n_i(hw_reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .link_configuration_o(link_configuration_o), .power_down_ctrl_o(power_down_ctrl_o), .eapd_o(eapd_o),
    .general_purpose_o(general_purpose_o), .chan_mute_o(chan_mute_o), .chan_atten_o(chan_atten_o));
`default_nettype wire

// ==== dv/ccrb_host_model.sv ====
// ccrb_host_model: host controller issuing register reads and writes
`timescale 1ns/100ps
`default_nettype none
module ccrb_host_model (
    input wire logic clk_i,
    input wire logic [ccrb_pkg::DATA_W-1:0] rdata_i,
    output logic [ccrb_pkg::ADDR_W-1:0] addr_o,
    output logic [ccrb_pkg::DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    import ccrb_pkg::*;
    initial begin
        addr_o = 7'h00;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // idle address and data are inverted so the design cannot lean on stale values
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dat);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= dat;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~dat;
    endtask : wr_reg
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] dat);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(negedge clk_i);
        dat = rdata_i;
    endtask : rd_reg
endmodule : ccrb_host_model
`default_nettype wire

// ==== dv/ccrb_bench.sv ====
// ccrb_bench: self-checking bench for the codec control register bank
`timescale 1ns/100ps
`default_nettype none
module ccrb_bench;
    import ccrb_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic hw_reset_n_i = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr_s;
    logic rd;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] link_cfg;
    logic [DATA_W-1:0] pwr;
    logic eapd;
    logic gpo;
    logic [NUM_CH-1:0] mute;
    logic [NUM_CH-1:0][ATT_W-1:0] att;
    logic [DATA_W-1:0] d;
    logic [6:0] ta [9] = '{7'h00, 7'h02, 7'h04, 7'h06, 7'h28, 7'h74, 7'h76, 7'h40, 7'h01};
    logic [15:0] te [9] = '{16'h0290, 16'h8080, 16'h8080, 16'h8000, 16'h0bc7, 16'h1001, 16'h6010, 16'h0, 16'h0};
    logic [7:0] ea [9];
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    always #20 clk_i = ~clk_i;
    ccrb_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hw_reset_n_i(hw_reset_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd), .rdata_o(rdata), .link_configuration_o(link_cfg),
        .power_down_ctrl_o(pwr), .eapd_o(eapd), .general_purpose_o(gpo), .chan_mute_o(mute), .chan_atten_o(att));
    ccrb_host_model u_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr_s),
        .rd_o(rd));
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk
    task rchk(input logic [6:0] a, input logic [15:0] exp);
        u_host.rd_reg(a, d);
        chk($sformatf("reg %h", a), exp, d);
    endtask : rchk
    task wr(input logic [6:0] a, input logic [15:0] v);
        u_host.wr_reg(a, v);
    endtask : wr
    // channel outputs trail the register by one edge
    task atten_chk();
        repeat (2) @(negedge clk_i);
        for (int i = 0; i < 9; i++) begin
            chk($sformatf("atten %0d", i), {8'h00, ea[i]}, {8'h00, att[i]});
        end
    endtask : atten_chk
    task conclude();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rchk(ta[i], te[i]);
        end
        $display("defaults done");
        wr(7'h00, 16'hffff);
        wr(7'h28, 16'hffff);
        wr(7'h76, 16'h0000);
        wr(7'h40, 16'hffff);
        rchk(7'h00, 16'h0290);
        rchk(7'h28, 16'h0bc7);
        rchk(7'h76, 16'h6000);
        rchk(7'h40, 16'h0000);
        $display("read-only done");
        wr(7'h02, 16'hffff);
        rchk(7'h02, 16'h9f9f);
        wr(7'h04, 16'h001f);
        wr(7'h06, 16'h0000);
        wr(7'h18, 16'h0808);
        wr(7'h38, 16'h0808);
        wr(7'h36, 16'h0808);
        repeat (2) @(negedge clk_i);
        chk("mute muted master", 16'h003f, {7'h0, mute});
        wr(7'h02, 16'h1f0f);
        ea = '{8'h1f, 8'h0f, 8'h1f, 8'h0f, 8'h0f, 8'h1f, 8'h00, 8'h1f, 8'h00};
        atten_chk();
        chk("mute open", 16'h0000, {7'h0, mute});
        wr(7'h18, 16'h0008);
        ea[0] = 8'h17;
        atten_chk();
        $display("volume done");
        wr(7'h26, 16'h8300);
        wr(7'h7a, 16'h0008);
        rchk(7'h26, 16'h830c);
        chk("power out", 16'h8300, pwr);
        chk("eapd gpo", 16'h0003, {14'h0, eapd, gpo});
        wr(7'h74, 16'hffff);
        wr(7'h24, 16'h0001);
        wr(7'h60, 16'h1234);
        wr(7'h6a, 16'hffff);
        wr(7'h00, 16'h0000);
        rchk(7'h74, 16'hf087);
        chk("link out", 16'hf087, link_cfg);
        rchk(7'h02, 16'h8080);
        chk("mute after sw reset", 16'h01ff, {7'h0, mute});
        chk("power after sw reset", 16'h0000, pwr);
        chk("eapd gpo after sw reset", 16'h0000, {14'h0, eapd, gpo});
        wr(7'h24, 16'h0001);
        rchk(7'h60, 16'h1234);
        rchk(7'h6a, 16'he000);
        $display("software reset done");
        @(posedge clk_i);
        hw_reset_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        hw_reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rchk(7'h74, 16'h1001);
        wr(7'h24, 16'h0001);
        rchk(7'h60, 16'h1234);
        rchk(7'h6a, 16'he000);
        $display("pin reset done");
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        wr(7'h24, 16'h0001);
        rchk(7'h60, 16'h0002);
        $display("power-on reset done");
        conclude();
    end
endmodule : ccrb_bench
`default_nettype wire
